// *** design/rcv_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// Function
// - cause register clears to 00H on pin reset and power-on clear; a read clears each bit not set in the same cycle
// - watchdog cause set on watchdog reset, held on monitor reset, else cleared
// - undervoltage cause set on monitor reset, held on watchdog reset
// - power-on clear asserts internal reset at power-up and low supply
// - control bit 7 enables the monitor comparator
// - control bit 1 selects interrupt (0) or internal reset (1)
// - control bit 0 is read-only undervoltage flag, zero when disabled
// - enable and mode bits clear on all resets except monitor reset
// - reset brings control register to 00H with that exception
// - enabled interrupt mode drives the flag onto the interrupt request
// - enabled reset mode undervoltage asserts reset and sets cause bit 0
// - monitor keeps working in stop standby
// - control accepts byte writes and single bit set or clear
// - ten selectable levels are passed to the comparator reference
// - level register holds 4-bit code, 00H reset, codes above 9 prohibited
module rcv_monitor
  import rcv_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       poc_low_i,
  input  wire logic       uv_cmp_i,
  input  wire logic       wdt_reset_i,
  input  wire logic       stop_mode_i,
  input  wire logic [15:0] addr_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       bit_op_i,
  input  wire logic [2:0] bit_sel_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  output logic            undervoltage_irq_o,
  output logic            internal_reset_o,
  output logic      [3:0] detect_level_select_o,
  output logic            cmp_enable_o
);
  typedef struct packed {
    logic       monitor_enable;
    logic       monitor_action_select;
    logic       undervoltage_flag;
    logic [3:0] level;
    logic       watchdog_cause_flag;
    logic       undervoltage_cause_flag;
    logic [7:0] rdata;
    logic       irq;
    logic       ireset;
  } rcv_state_t;

  rcv_state_t st_r;
  rcv_state_t st_nxt;
  logic       uv_s;
  logic       poc_s;
  logic [7:0] ctrl_v;
  logic [7:0] ctrl_w;
  logic       uv_trip;

  // comparators are asynchronous analog outputs
  rcv_sync u_uv (.clock_i(clock_i), .d_i(uv_cmp_i), .q_o(uv_s));
  rcv_sync u_poc (.clock_i(clock_i), .d_i(poc_low_i), .q_o(poc_s));

  function automatic logic [7:0] rcv_bitwrite(input logic [7:0] old,
                                              input logic       bop,
                                              input logic [2:0] sel,
                                              input logic [7:0] d);
    logic [7:0] r;
    r = d;
    if (bop) begin
      r = old;
      r[sel] = d[0];
    end
    return r;
  endfunction

  always_comb begin
    st_nxt = st_r;
    ctrl_v = 8'h00;
    ctrl_v[RCV_EN_BIT]   = st_r.monitor_enable;
    ctrl_v[RCV_MODE_BIT] = st_r.monitor_action_select;
    ctrl_v[RCV_UV_BIT]   = st_r.undervoltage_flag;
    ctrl_w = rcv_bitwrite(ctrl_v, bit_op_i, bit_sel_i, wdata_i);
    // flag follows comparator while enabled, also in stop mode
    st_nxt.undervoltage_flag = st_r.monitor_enable & uv_s;
    uv_trip = st_r.monitor_enable & st_r.monitor_action_select
              & st_r.undervoltage_flag;
    st_nxt.irq = st_r.monitor_enable & ~st_r.monitor_action_select
                 & st_r.undervoltage_flag;
    if (wr_i && addr_i == RCV_CTRL_ADDR) begin
      st_nxt.monitor_enable        = ctrl_w[RCV_EN_BIT];
      st_nxt.monitor_action_select = ctrl_w[RCV_MODE_BIT];
    end
    if (wr_i && addr_i == RCV_LEVEL_ADDR && !bit_op_i &&
        wdata_i[3:0] <= RCV_LEVEL_MAX) begin
      st_nxt.level = wdata_i[3:0];
    end
    st_nxt.rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        RCV_CTRL_ADDR:  st_nxt.rdata = ctrl_v;
        RCV_LEVEL_ADDR: st_nxt.rdata = {4'h0, st_r.level};
        RCV_CAUSE_ADDR: begin
          st_nxt.rdata[RCV_WDT_CAUSE_BIT] = st_r.watchdog_cause_flag;
          st_nxt.rdata[RCV_UV_CAUSE_BIT]  = st_r.undervoltage_cause_flag;
          st_nxt.watchdog_cause_flag     = 1'b0;
          st_nxt.undervoltage_cause_flag = 1'b0;
        end
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    // set beats the read clear
    if (wdt_reset_i) begin
      st_nxt.watchdog_cause_flag = 1'b1;
      st_nxt.monitor_enable        = 1'b0;
      st_nxt.monitor_action_select = 1'b0;
      st_nxt.level                 = RCV_LEVEL_RST[3:0];
      st_nxt.irq                   = 1'b0;
    end
    if (uv_trip) begin
      // enable and mode are held so the monitor stays armed
      st_nxt.undervoltage_cause_flag = 1'b1;
      st_nxt.irq                     = 1'b0;
    end
    st_nxt.ireset = poc_s | uv_trip | wdt_reset_i;
    if (!rst_n_i || poc_s) begin
      st_nxt = '0;
      st_nxt.level  = RCV_LEVEL_RST[3:0];
      st_nxt.ireset = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    st_r <= st_nxt;
  end

  assign rdata_o               = st_r.rdata;
  assign undervoltage_irq_o    = st_r.irq;
  assign internal_reset_o      = st_r.ireset;
  assign detect_level_select_o = st_r.level;
  assign cmp_enable_o          = st_r.monitor_enable;

  sequence s_trip;
    st_r.monitor_enable && st_r.monitor_action_select
      && st_r.undervoltage_flag;
  endsequence

  // flag rises while the monitor is armed for interrupts
  sequence s_flag_rise;
    !st_r.undervoltage_flag ##1
      st_r.undervoltage_flag && st_r.monitor_enable
      && !st_r.monitor_action_select;
  endsequence

  a_trip_sets_cause: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (s_trip and !poc_s)
      |=> internal_reset_o && st_r.undervoltage_cause_flag)
    else $error("monitor trip missed reset or cause");
  a_trip_holds_ctrl: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (s_trip and (!poc_s && !wdt_reset_i && !wr_i))
      |=> st_r.monitor_enable)
    else $error("monitor reset cleared enable");
  a_poc_resets: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    poc_s |=> internal_reset_o && st_r.rdata == 8'h00
      && !st_r.watchdog_cause_flag)
    else $error("power-on clear did not reset");
  a_wdt_sets_cause: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    wdt_reset_i && !poc_s |=> st_r.watchdog_cause_flag
      && !st_r.monitor_enable)
    else $error("watchdog cause not set");

  // a set in the same cycle wins over the read clear
  a_read_clears: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    rd_i && addr_i == RCV_CAUSE_ADDR && !wdt_reset_i && !uv_trip
      |=> !st_r.watchdog_cause_flag && !st_r.undervoltage_cause_flag)
    else $error("cause not cleared by read");
  a_flag_disabled: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !st_r.monitor_enable |=> !st_r.undervoltage_flag)
    else $error("flag set while disabled");
  a_irq_follows: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    st_r.monitor_enable && !st_r.monitor_action_select && !poc_s
      && !wdt_reset_i
      |=> undervoltage_irq_o == $past(st_r.undervoltage_flag))
    else $error("irq does not follow flag");
  a_irq_raise: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_flag_rise ##0 (!poc_s && !wdt_reset_i) |=> undervoltage_irq_o)
    else $error("irq missed rising flag");
  a_mode_no_irq: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    st_r.monitor_action_select |=> !undervoltage_irq_o)
    else $error("irq raised in reset mode");
  a_level_legal: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    detect_level_select_o <= RCV_LEVEL_MAX)
    else $error("illegal level stored");
  a_ctrl_reserved: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    rd_i && addr_i == RCV_CTRL_ADDR |=> rdata_o[6:2] == 5'h00)
    else $error("reserved control bits read back set");

  // three edges from pin to flag: two sync stages plus the flag register
  a_sync_delay: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    $past(st_r.monitor_enable) && $past(rst_n_i) && !$past(poc_s)
      |-> st_r.undervoltage_flag == $past(uv_cmp_i, 3))
    else $error("flag not three edges behind comparator");
  a_stop_monitors: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    stop_mode_i && st_r.monitor_enable && !poc_s
      |=> st_r.undervoltage_flag == $past(uv_s))
    else $error("monitor idle in stop standby");

  // the pin reset itself is the subject here, so nothing disables it
  a_pin_clears: assert property (
    @(posedge clock_i)
    !rst_n_i |=> internal_reset_o && !st_r.monitor_enable
      && !st_r.watchdog_cause_flag && !st_r.undervoltage_cause_flag
      && detect_level_select_o == RCV_LEVEL_RST[3:0])
    else $error("pin reset left state behind");

  // watchdog and monitor resets each leave the other source's cause flag alone
  a_wdt_holds_uv: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    wdt_reset_i && !poc_s && !uv_trip
      && !(rd_i && addr_i == RCV_CAUSE_ADDR)
      |=> st_r.undervoltage_cause_flag
          == $past(st_r.undervoltage_cause_flag))
    else $error("watchdog reset changed undervoltage cause");
  a_trip_holds_wdt: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    uv_trip && !poc_s && !wdt_reset_i
      && !(rd_i && addr_i == RCV_CAUSE_ADDR)
      |=> st_r.watchdog_cause_flag == $past(st_r.watchdog_cause_flag))
    else $error("monitor reset changed watchdog cause");
endmodule
`default_nettype wire

// *** include/rcv_pkg.sv ***
package rcv_pkg;
  localparam logic [15:0] RCV_CTRL_ADDR      = 16'hff50;
  localparam logic [15:0] RCV_LEVEL_ADDR     = 16'hff51;
  localparam logic [15:0] RCV_CAUSE_ADDR     = 16'hff52;
  localparam logic [7:0]  RCV_CTRL_RST       = 8'h00;
  localparam logic [7:0]  RCV_LEVEL_RST      = 8'h00;
  localparam logic [7:0]  RCV_CAUSE_RST      = 8'h00;
  localparam int          RCV_EN_BIT         = 7;
  localparam int          RCV_MODE_BIT       = 1;
  localparam int          RCV_UV_BIT         = 0;
  localparam int          RCV_WDT_CAUSE_BIT  = 1;
  localparam int          RCV_UV_CAUSE_BIT   = 0;
  localparam logic [3:0]  RCV_LEVEL_MAX      = 4'h9;
  localparam int          RCV_CLK_MHZ        = 200;
  localparam int          RCV_SETTLE_US_X10  = 2000;
  localparam int          RCV_SETTLE_CYC     = RCV_SETTLE_US_X10 * RCV_CLK_MHZ / 10;
endpackage

// *** design/rcv_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module rcv_sync (
  input  wire logic clock_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic s1_r;
  always_ff @(posedge clock_i) begin
    s1_r <= d_i;
    q_o  <= s1_r;
  end
endmodule
`default_nettype wire

// *** verif/reset_cause_and_voltage_monitor_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
  $display("ERROR %0t got %h exp %h", $time, a, e); end end
module reset_cause_and_voltage_monitor_tb;
  import rcv_pkg::*;
  logic        clock_i = 0, rst_n_i = 0, poc_low_i = 0, uv_cmp_i = 0;
  logic        wdt_reset_i = 0, stop_mode_i = 0, wr_i = 0, rd_i = 0;
  logic        bit_op_i = 0, undervoltage_irq_o, internal_reset_o;
  logic        cmp_enable_o;
  logic [15:0] addr_i = 0;
  logic [2:0]  bit_sel_i = 0;
  logic [7:0]  wdata_i = 0, rdata_o;
  logic [3:0]  detect_level_select_o;
  int          err_count = 0, n_checks = 0, en = 0, md = 0, lvl = 0, v;
  int          wdc = 0, uvc = 0;
  logic [7:0]  exp_q[$];
  always #2.5 clock_i = ~clock_i;
  rcv_monitor DUT (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .poc_low_i(poc_low_i), .uv_cmp_i(uv_cmp_i), .wdt_reset_i(wdt_reset_i),
    .stop_mode_i(stop_mode_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .bit_op_i(bit_op_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .undervoltage_irq_o(undervoltage_irq_o),
    .internal_reset_o(internal_reset_o), .cmp_enable_o(cmp_enable_o),
    .detect_level_select_o(detect_level_select_o));
  task automatic cyc(int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d, logic b, logic [2:0] s);
    @(posedge clock_i);
    addr_i <= a; wdata_i <= d; bit_op_i <= b; bit_sel_i <= s; wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd_chk(logic [15:0] a, logic [7:0] e);
    logic [7:0] x;
    exp_q.push_back(e);
    @(posedge clock_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 x = exp_q.pop_front();
    `CHK(rdata_o, x)
  endtask
  // bounded wait: the internal reset level follows synced inputs
  task automatic wait_rst(logic want);
    repeat (40) if (internal_reset_o !== want) @(posedge clock_i);
    #1 `CHK(internal_reset_o, want)
  endtask
  // model view of control and level registers; uv is the expected comparator
  task automatic chk_all(int uv);
    rd_chk(RCV_CTRL_ADDR, {en[0], 5'h00, md[0], uv[0] & en[0]});
    rd_chk(RCV_LEVEL_ADDR, {4'h0, lvl[3:0]});
    `CHK(cmp_enable_o, en[0])
    `CHK(detect_level_select_o, lvl[3:0])
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // model of the cause flags: a byte read hands them back and clears them
  task automatic rd_cause;
    rd_chk(RCV_CAUSE_ADDR, {6'h00, wdc[0], uvc[0]});
    wdc = 0;
    uvc = 0;
  endtask
  // watchdog reset: sets its cause, clears control and level
  task automatic wdt_pulse;
    @(posedge clock_i) wdt_reset_i <= 1'b1;
    @(posedge clock_i) wdt_reset_i <= 1'b0;
    wdc = 1;
    en = 0; md = 0; lvl = 0;
  endtask
  // budget covers the settle wait plus every scenario with room to spare
  initial begin
    repeat (RCV_SETTLE_CYC + 4000) @(posedge clock_i);
    err_count++;
    give_verdict();
  end
  initial begin
    v = $urandom(53);
    cyc(3);
    rst_n_i <= 1'b1;
    #1 `CHK(internal_reset_o, 1'b1)
    wait_rst(1'b0);
    rd_cause();
    chk_all(0);
    // reserved bits written as zero; bit 0 is read-only and refused
    wr(RCV_CTRL_ADDR, 8'h83, 1'b0, 3'h0);
    en = 1; md = 1;
    chk_all(0);
    wr(RCV_CTRL_ADDR, 8'h00, 1'b0, 3'h0);
    en = 0; md = 0;
    chk_all(0);
    wr(RCV_CTRL_ADDR, 8'h01, 1'b1, 3'h7);
    wr(RCV_CTRL_ADDR, 8'h01, 1'b1, 3'h1);
    wr(RCV_CTRL_ADDR, 8'h00, 1'b1, 3'h1);
    en = 1;
    cyc(RCV_SETTLE_CYC);
    chk_all(0);
    @(posedge clock_i);
    stop_mode_i <= 1'b1;
    uv_cmp_i <= 1'b1;
    cyc(6);
    #1 `CHK(undervoltage_irq_o, 1'b1)
    chk_all(1);
    @(posedge clock_i);
    uv_cmp_i <= 1'b0;
    cyc(6);
    #1 `CHK(undervoltage_irq_o, 1'b0)
    @(posedge clock_i);
    stop_mode_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      v = $urandom % 16;
      wr(RCV_LEVEL_ADDR, {4'h0, v[3:0]}, 1'b0, 3'h0);
      if (v <= 9) lvl = v;
      chk_all(0);
    end
    wr(RCV_LEVEL_ADDR, 8'h0c, 1'b0, 3'h0);
    wr(RCV_LEVEL_ADDR, 8'h01, 1'b1, 3'h3);
    chk_all(0);
    wr(RCV_CTRL_ADDR, 8'h01, 1'b1, 3'h1);
    md = 1;
    @(posedge clock_i);
    uv_cmp_i <= 1'b1;
    wait_rst(1'b1);
    uvc = 1;
    `CHK(undervoltage_irq_o, 1'b0)
    @(posedge clock_i);
    uv_cmp_i <= 1'b0;
    wait_rst(1'b0);
    chk_all(0);
    wdt_pulse();
    #1 `CHK(internal_reset_o, 1'b1)
    cyc(3);
    wait_rst(1'b0);
    chk_all(0);
    rd_cause();
    rd_cause();
    wdt_pulse();
    cyc(3);
    poc_low_i <= 1'b1;
    cyc(6);
    #1 `CHK(internal_reset_o, 1'b1)
    @(posedge clock_i);
    poc_low_i <= 1'b0;
    wait_rst(1'b0);
    wdc = 0; uvc = 0;
    rd_cause();
    // pin reset in mid-run must clear the cause a watchdog left behind
    wdt_pulse();
    cyc(3);
    rst_n_i <= 1'b0;
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    #1 `CHK(internal_reset_o, 1'b1)
    wait_rst(1'b0);
    wdc = 0; uvc = 0;
    rd_cause();
    chk_all(0);
    rd_chk(16'hff53, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
